// >>> include/cafm_pkg.sv
// Constants, register map and buffer layout for the CAN acceptance filter and message buffers.
// Notes on behaviour
// - Error counter readable only in sleep/init modes.
// - Frames land in background buffer first.
// - Filter compares identifier bytes bit by bit.
// - Extended uses four pairs, standard two.
// - Codes reset zero, written in init only.
// - Transmit buffer writable when empty and selected.
// - Receive buffer valid only while full flag.
// - Buffer storage is not reset.
// - Extended identifier area spans 32 bits.
// - Standard identifier area holds 13 bits.
// - Identifier MSB first; lower identifier wins.
// - Standard: ID low bits 7:5, RTR 4, IDE 3.
// - RTR zero data frame, one remote frame.
// - IDE zero standard, one extended format.
// - Eight payload bytes, length code limits valid.
package cafm_pkg;
	localparam int ADDR_W = 8;
	// Register byte addresses, one 32-bit word each.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MODE_STAT = 8'h04;
	localparam logic [7:0] OFF_RXFLAG = 8'h08;
	localparam logic [7:0] OFF_TXEMPTY = 8'h0c;
	localparam logic [7:0] OFF_TBSEL = 8'h10;
	localparam logic [7:0] OFF_TXERR = 8'h14;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
	localparam logic [7:0] OFF_CODE0 = 8'h20;
	localparam logic [7:0] OFF_MASK0 = 8'h30;
	localparam logic [1:0] REGION_REGS = 2'h0;
	localparam logic [1:0] REGION_RXBUF = 2'h1;
	localparam logic [1:0] REGION_TXBUF = 2'h2;
	localparam int REGION_LSB = 6;
	localparam int NUM_FILTER = 4;
	localparam int NUM_STD_FILTER = 2;
	// Control and flag bit positions.
	localparam int CTRL_SLEEP_BIT = 0;
	localparam int CTRL_INIT_BIT = 1;
	localparam int RXF_BIT = 0;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_TX_BIT = 1;
	localparam int IRQ_OVR_BIT = 2;
	localparam int IRQ_W = 3;
	// Message buffer slot layout, one byte per word.
	localparam int BUF_SLOTS = 16;
	localparam int SLOT_IDR0 = 0;
	localparam int SLOT_IDENT_BYTE_ONE = 1;
	localparam int SLOT_IDR3 = 3;
	localparam int SLOT_DATA0 = 4;
	localparam int SLOT_DLC = 12;
	localparam int MAX_BYTES = 8;
	localparam int IDE_BIT = 3;
	localparam int STD_RTR_BIT = 4;
	localparam int EXT_RTR_BIT = 0;
	// Reset values.
	localparam logic [7:0] CODE_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage : cafm_pkg

// >>> design/cafm_top.sv
// Acceptance filter, message buffers and APB register file of the CAN controller.
//
// Design decisions made here: the APB slave port and the register offsets.
module cafm_top #(
	parameter int NUM_TXBUF = 3,
	localparam int TW = (NUM_TXBUF > 1) ? $clog2(NUM_TXBUF) : 1
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic o_pslverr,
	output logic [31:0] o_prdata,
	// Mode handshake with the protocol engine
	output logic o_sleep_request,
	output logic o_init_request,
	input wire logic i_sleep_acknowledge,
	input wire logic i_init_acknowledge,
	input wire logic [7:0] i_tx_error_count,
	// Received frames from the protocol engine
	input wire logic i_rx_valid,
	input wire logic [31:0] i_rx_ident,
	input wire logic [3:0] i_rx_dlc,
	input wire logic [63:0] i_rx_payload,
	// Frames offered to the protocol engine
	output logic [NUM_TXBUF-1:0] o_tx_pending,
	output logic o_tx_valid,
	output logic [TW-1:0] o_tx_index,
	output logic [31:0] o_tx_ident,
	output logic o_tx_ide,
	output logic o_tx_rtr,
	output logic [3:0] o_tx_dlc,
	output logic [63:0] o_tx_payload,
	input wire logic i_tx_done,
	input wire logic [TW-1:0] i_tx_done_index,
	// Interrupt
	output logic o_irq
);
	logic sleep_req_q;
	logic init_req_q;
	logic [7:0] code_q [cafm_pkg::NUM_FILTER];
	logic [7:0] mask_q [cafm_pkg::NUM_FILTER];
	logic rxf_q;
	logic [NUM_TXBUF-1:0] txe_q;
	logic [TW-1:0] tbsel_q;
	logic [cafm_pkg::IRQ_W-1:0] irq_stat_q;
	logic [cafm_pkg::IRQ_W-1:0] irq_mask_q;
	logic [cafm_pkg::IRQ_W-1:0] irq_seen_q;
	logic [cafm_pkg::IRQ_W-1:0] irq_ev;
	logic [7:0] rx_mem [cafm_pkg::BUF_SLOTS];
	logic [7:0] tx_mem [NUM_TXBUF][cafm_pkg::BUF_SLOTS];
	logic [31:0] bg_ident_q;
	logic [3:0] bg_dlc_q;
	logic [63:0] bg_payload_q;
	logic bg_pending_q;
	logic accept;
	logic copy_rx;
	logic setup;
	logic wr_en;
	logic rd_take;
	logic init_mode;
	logic sleep_mode;
	logic [3:0] slot;
	logic [1:0] region;
	logic [31:0] rd_data;
	logic rd_err;
	logic tx_wr_ok;
	logic [3:0] rx_len;
	logic [TW-1:0] pick;
	logic pick_valid;
	// Identifier byte 1 sits at bits 23:16 of the frame word, so its IDE flag lands here.
	localparam int IDE_POS = 8 * (cafm_pkg::SLOT_IDR3 - cafm_pkg::SLOT_IDENT_BYTE_ONE) + cafm_pkg::IDE_BIT;

	assign setup = i_psel & ~i_penable;
	assign wr_en = i_psel & i_penable & i_pwrite & o_pready & i_pstrb[0] & ~o_pslverr;
	assign rd_take = i_psel & i_penable & ~i_pwrite & o_pready;
	assign init_mode = init_req_q & i_init_acknowledge;
	assign sleep_mode = sleep_req_q & i_sleep_acknowledge;
	assign slot = i_paddr[5:2];
	assign region = i_paddr[7:cafm_pkg::REGION_LSB];
	// Payload beyond the length code is never reported as valid data.
	assign rx_len = (rx_mem[cafm_pkg::SLOT_DLC][3:0] > 4'(cafm_pkg::MAX_BYTES)) ?
		4'(cafm_pkg::MAX_BYTES) : rx_mem[cafm_pkg::SLOT_DLC][3:0];
	assign tx_wr_ok = (32'(tbsel_q) < NUM_TXBUF) && txe_q[tbsel_q];

	// Identifier filter on the background frame.
	always_comb begin
		accept = 1'b1;
		for (int b = 0; b < cafm_pkg::NUM_FILTER; b++) begin
			// The IDE bit sits in the second identifier byte in both mappings.
			if (b < cafm_pkg::NUM_STD_FILTER || bg_ident_q[IDE_POS]) begin
				if (((bg_ident_q[31 - 8 * b -: 8] ^ code_q[b]) & ~mask_q[b]) != 8'h00) begin
					accept = 1'b0;
				end
			end
		end
	end

	assign copy_rx = bg_pending_q & accept & ~rxf_q;

	// Background buffer: every frame lands here and the next one overwrites it.
	always_ff @(posedge i_core_clk) begin
		if (i_rx_valid) begin
			bg_ident_q <= i_rx_ident;
			bg_dlc_q <= i_rx_dlc;
			bg_payload_q <= i_rx_payload;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bg_pending_q <= 1'b0;
		end else begin
			bg_pending_q <= i_rx_valid;
		end
	end

	// Foreground receive buffer holds no reset, like the RAM it models.
	always_ff @(posedge i_core_clk) begin
		if (copy_rx) begin
			for (int b = 0; b < 4; b++) begin
				rx_mem[cafm_pkg::SLOT_IDR0 + b] <= bg_ident_q[31 - 8 * b -: 8];
			end
			for (int d = 0; d < cafm_pkg::MAX_BYTES; d++) begin
				rx_mem[cafm_pkg::SLOT_DATA0 + d] <= bg_payload_q[63 - 8 * d -: 8];
			end
			rx_mem[cafm_pkg::SLOT_DLC] <= {4'h0, bg_dlc_q};
		end
	end

	// Transmit buffers are written only through the selected, empty buffer.
	always_ff @(posedge i_core_clk) begin
		if (wr_en && region == cafm_pkg::REGION_TXBUF && tx_wr_ok) begin
			tx_mem[tbsel_q][slot] <= i_pwdata[7:0];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sleep_req_q <= 1'b0;
			init_req_q <= 1'b0;
		end else if (wr_en && i_paddr == cafm_pkg::OFF_CTRL) begin
			sleep_req_q <= i_pwdata[cafm_pkg::CTRL_SLEEP_BIT];
			init_req_q <= i_pwdata[cafm_pkg::CTRL_INIT_BIT];
		end
	end

	// Filter setup is frozen outside initialization mode so a live filter never tears.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int b = 0; b < cafm_pkg::NUM_FILTER; b++) begin
				code_q[b] <= cafm_pkg::CODE_RST;
			end
		end else if (wr_en && init_mode) begin
			for (int b = 0; b < cafm_pkg::NUM_FILTER; b++) begin
				if (i_paddr == cafm_pkg::OFF_CODE0 + 8'(4 * b)) begin
					code_q[b] <= i_pwdata[7:0];
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int b = 0; b < cafm_pkg::NUM_FILTER; b++) begin
				mask_q[b] <= cafm_pkg::MASK_RST;
			end
		end else if (wr_en && init_mode) begin
			for (int b = 0; b < cafm_pkg::NUM_FILTER; b++) begin
				if (i_paddr == cafm_pkg::OFF_MASK0 + 8'(4 * b)) begin
					mask_q[b] <= i_pwdata[7:0];
				end
			end
		end
	end

	// Receive-full flag: a frame arriving while it is set is an overrun, so a software clear in the same cycle still takes effect.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rxf_q <= 1'b0;
		end else if (copy_rx) begin
			rxf_q <= 1'b1;
		end else if (wr_en && i_paddr == cafm_pkg::OFF_RXFLAG && i_pwdata[cafm_pkg::RXF_BIT]) begin
			rxf_q <= 1'b0;
		end
	end

	// Transmit-empty flags: software clears to queue, completion sets and wins.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			txe_q <= '1;
		end else begin
			for (int i = 0; i < NUM_TXBUF; i++) begin
				if (i_tx_done && 32'(i_tx_done_index) == i) begin
					txe_q[i] <= 1'b1;
				end else if (wr_en && i_paddr == cafm_pkg::OFF_TXEMPTY && i_pwdata[i]) begin
					txe_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tbsel_q <= '0;
		end else if (wr_en && i_paddr == cafm_pkg::OFF_TBSEL && 32'(i_pwdata[TW-1:0]) < NUM_TXBUF) begin
			tbsel_q <= i_pwdata[TW-1:0];
		end
	end

	assign irq_ev[cafm_pkg::IRQ_RX_BIT] = copy_rx;
	assign irq_ev[cafm_pkg::IRQ_TX_BIT] = i_tx_done;
	assign irq_ev[cafm_pkg::IRQ_OVR_BIT] = bg_pending_q & accept & rxf_q;

	// Only bits that the read actually returned are cleared, so a late event survives.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_stat_q <= '0;
		end else if (rd_take && i_paddr == cafm_pkg::OFF_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~irq_seen_q) | irq_ev;
		end else begin
			irq_stat_q <= irq_stat_q | irq_ev;
		end
	end

	// The snapshot is taken in the cycle that also fills the read data.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_seen_q <= '0;
		end else if (setup) begin
			irq_seen_q <= irq_stat_q;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_mask_q <= '0;
		end else if (wr_en && i_paddr == cafm_pkg::OFF_IRQ_MASK) begin
			irq_mask_q <= i_pwdata[cafm_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Read decode, evaluated in the setup cycle.
	always_comb begin
		rd_data = cafm_pkg::RDATA_RST;
		rd_err = 1'b0;
		if (i_paddr[1:0] != 2'h0) begin
			rd_err = 1'b1;
		end else if (region == cafm_pkg::REGION_RXBUF) begin
			// Stale contents stay hidden until a frame is really there.
			if (rxf_q) begin
				if (slot < 4'(cafm_pkg::SLOT_DATA0) || slot == 4'(cafm_pkg::SLOT_DLC)) begin
					rd_data[7:0] = rx_mem[slot];
				end else if (slot < 4'(cafm_pkg::SLOT_DATA0) + rx_len) begin
					rd_data[7:0] = rx_mem[slot];
				end
			end
		end else if (region == cafm_pkg::REGION_TXBUF) begin
			rd_data[7:0] = tx_mem[tbsel_q][slot];
		end else if (region == cafm_pkg::REGION_REGS) begin
			case (i_paddr)
				cafm_pkg::OFF_CTRL: begin
					rd_data[cafm_pkg::CTRL_SLEEP_BIT] = sleep_req_q;
					rd_data[cafm_pkg::CTRL_INIT_BIT] = init_req_q;
				end
				cafm_pkg::OFF_MODE_STAT: begin
					rd_data[cafm_pkg::CTRL_SLEEP_BIT] = i_sleep_acknowledge;
					rd_data[cafm_pkg::CTRL_INIT_BIT] = i_init_acknowledge;
				end
				cafm_pkg::OFF_RXFLAG: rd_data[cafm_pkg::RXF_BIT] = rxf_q;
				cafm_pkg::OFF_TXEMPTY: rd_data[NUM_TXBUF-1:0] = txe_q;
				cafm_pkg::OFF_TBSEL: rd_data[TW-1:0] = tbsel_q;
				cafm_pkg::OFF_TXERR: begin
					// The counter moves while the bus runs, so it only reads in quiet modes.
					if (sleep_mode || init_mode) begin
						rd_data[7:0] = i_tx_error_count;
					end
				end
				cafm_pkg::OFF_IRQ_STAT: rd_data[cafm_pkg::IRQ_W-1:0] = irq_stat_q;
				cafm_pkg::OFF_IRQ_MASK: rd_data[cafm_pkg::IRQ_W-1:0] = irq_mask_q;
				default: begin
					rd_err = 1'b1;
					for (int b = 0; b < cafm_pkg::NUM_FILTER; b++) begin
						if (i_paddr == cafm_pkg::OFF_CODE0 + 8'(4 * b)) begin
							rd_data[7:0] = code_q[b];
							rd_err = 1'b0;
						end
						if (i_paddr == cafm_pkg::OFF_MASK0 + 8'(4 * b)) begin
							rd_data[7:0] = mask_q[b];
							rd_err = 1'b0;
						end
					end
				end
			endcase
		end else begin
			rd_err = 1'b1;
		end
	end

	// No wait state: ready is registered from the setup cycle, so every bus output comes from a flip-flop.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= cafm_pkg::RDATA_RST;
		end else begin
			o_pready <= setup;
			if (setup) begin
				o_pslverr <= rd_err;
				o_prdata <= i_pwrite ? cafm_pkg::RDATA_RST : rd_data;
			end
		end
	end

	// Lowest-numbered queued buffer is offered first; bus arbitration orders nodes.
	always_comb begin
		pick = '0;
		pick_valid = 1'b0;
		for (int i = NUM_TXBUF - 1; i >= 0; i--) begin
			if (!txe_q[i]) begin
				pick = TW'(i);
				pick_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_tx_ident <= '0;
			o_tx_ide <= 1'b0;
			o_tx_rtr <= 1'b0;
			o_tx_dlc <= '0;
			o_tx_payload <= '0;
		end else begin
			// Byte 0 goes to the top, so the identifier MSB sits at bit 31 and leaves first.
			o_tx_ident <= {tx_mem[pick][cafm_pkg::SLOT_IDR0], tx_mem[pick][cafm_pkg::SLOT_IDENT_BYTE_ONE],
				tx_mem[pick][cafm_pkg::SLOT_IDENT_BYTE_ONE + 1], tx_mem[pick][cafm_pkg::SLOT_IDR3]};
			o_tx_ide <= tx_mem[pick][cafm_pkg::SLOT_IDENT_BYTE_ONE][cafm_pkg::IDE_BIT];
			// The remote bit moves between mappings; standard keeps ID low bits in 7:5.
			o_tx_rtr <= tx_mem[pick][cafm_pkg::SLOT_IDENT_BYTE_ONE][cafm_pkg::IDE_BIT] ?
				tx_mem[pick][cafm_pkg::SLOT_IDR3][cafm_pkg::EXT_RTR_BIT] :
				tx_mem[pick][cafm_pkg::SLOT_IDENT_BYTE_ONE][cafm_pkg::STD_RTR_BIT];
			o_tx_dlc <= tx_mem[pick][cafm_pkg::SLOT_DLC][3:0];
			for (int d = 0; d < cafm_pkg::MAX_BYTES; d++) begin
				o_tx_payload[63 - 8 * d -: 8] <= tx_mem[pick][cafm_pkg::SLOT_DATA0 + d];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_tx_pending <= '0;
			o_tx_valid <= 1'b0;
			o_tx_index <= '0;
		end else begin
			o_tx_pending <= ~txe_q;
			o_tx_valid <= pick_valid;
			o_tx_index <= pick;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sleep_request <= 1'b0;
			o_init_request <= 1'b0;
		end else begin
			o_sleep_request <= sleep_req_q;
			o_init_request <= init_req_q;
		end
	end
endmodule : cafm_top

// >>> bench/cafm_chk_sva.sv
// Concurrent checks on the register port and the transmit side of the acceptance filter block.
module cafm_chk #(
	parameter int NUM_TXBUF = 3,
	localparam int TW = (NUM_TXBUF > 1) ? $clog2(NUM_TXBUF) : 1
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// APB
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [31:0] o_prdata,
	// Mode handshake
	input wire logic o_sleep_request,
	input wire logic o_init_request,
	input wire logic i_sleep_acknowledge,
	input wire logic i_init_acknowledge,
	input wire logic [7:0] i_tx_error_count,
	// Transmit side
	input wire logic [NUM_TXBUF-1:0] o_tx_pending,
	input wire logic o_tx_valid,
	input wire logic [TW-1:0] o_tx_index,
	input wire logic [31:0] o_tx_ident,
	input wire logic o_tx_ide,
	input wire logic o_tx_rtr,
	input wire logic i_tx_done,
	input wire logic [TW-1:0] i_tx_done_index
);
	logic bad_addr;
	logic init_wbit;
	logic [NUM_TXBUF-1:0] below_idx;
	assign bad_addr = (i_paddr[1:0] != 2'h0) || (i_paddr[7:6] == 2'h3);
	assign init_wbit = i_pwdata[cafm_pkg::CTRL_INIT_BIT];
	assign below_idx = NUM_TXBUF'((1 << o_tx_index) - 1);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);
	sequence apb_setup_s;
		i_psel && !i_penable;
	endsequence
	sequence apb_done_s;
		i_psel && i_penable && o_pready;
	endsequence
	ready_after_setup_a: assert property (apb_setup_s |=> o_pready) else $error("no ready after setup");
	ready_one_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held too long");
	addr_error_a: assert property (apb_done_s |-> o_pslverr == bad_addr) else $error("slave error wrong");
	txerr_gate_a: assert property (apb_done_s ##0 (!i_pwrite && i_paddr == cafm_pkg::OFF_TXERR) |->
		o_prdata == (((o_sleep_request && $past(i_sleep_acknowledge)) ||
		(o_init_request && $past(i_init_acknowledge))) ? {24'h0, $past(i_tx_error_count)} : 32'h0))
		else $error("error count gate wrong");
	init_follow_a: assert property (apb_done_s ##0 (i_pwrite && i_paddr == cafm_pkg::OFF_CTRL && i_pstrb[0])
		|=> ##1 o_init_request == $past(init_wbit, 2)) else $error("init request not updated");
	tx_valid_any_a: assert property (o_tx_valid == (o_tx_pending != '0)) else $error("valid vs pending");
	tx_lowest_a: assert property (o_tx_valid |-> o_tx_pending[o_tx_index] && (o_tx_pending & below_idx) == '0)
		else $error("offered buffer not lowest pending");
	tx_format_a: assert property (o_tx_valid |-> o_tx_ide == o_tx_ident[19] &&
		o_tx_rtr == (o_tx_ide ? o_tx_ident[0] : o_tx_ident[20])) else $error("ide or rtr mismatch");
	tx_done_clear_a: assert property (i_tx_done |-> ##2 !o_tx_pending[$past(i_tx_done_index, 2)])
		else $error("done buffer still pending");
endmodule : cafm_chk

bind cafm_top cafm_chk #(.NUM_TXBUF(NUM_TXBUF)) u_chk (.i_core_clk, .i_resetn, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_pslverr, .o_prdata, .o_sleep_request,
	.o_init_request, .i_sleep_acknowledge, .i_init_acknowledge, .i_tx_error_count, .o_tx_pending,
	.o_tx_valid, .o_tx_index, .o_tx_ident, .o_tx_ide, .o_tx_rtr, .i_tx_done, .i_tx_done_index);

// >>> bench/cafm_engine_model.sv
// Behavioural protocol engine standing for the other bus nodes behind the filter block.
module cafm_engine_model #(
	parameter int TW = 2,
	parameter logic [7:0] ERR_COUNT = 8'h2a,
	parameter int DONE_DLY = 40
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Mode handshake
	input wire logic i_sleep_request,
	input wire logic i_init_request,
	output logic o_sleep_acknowledge,
	output logic o_init_acknowledge,
	output logic [7:0] o_tx_error_count,
	// Received frames
	output logic o_rx_valid,
	output logic [31:0] o_rx_ident,
	output logic [3:0] o_rx_dlc,
	output logic [63:0] o_rx_payload,
	// Transmit side
	input wire logic i_tx_valid,
	input wire logic [TW-1:0] i_tx_index,
	output logic o_tx_done,
	output logic [TW-1:0] o_tx_done_index
);
	logic [5:0] ack_q;
	int cnt_q;
	assign o_sleep_acknowledge = ack_q[5];
	assign o_init_acknowledge = ack_q[4];
	assign o_tx_error_count = ERR_COUNT;
	initial begin
		o_rx_valid = 1'b0;
		o_rx_ident = 32'h0;
		o_rx_dlc = 4'h0;
		o_rx_payload = 64'h0;
	end
	// Mode changes are acknowledged a few cycles late, as a real engine finishing its frame would.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ack_q <= 6'h00;
		end else begin
			ack_q <= {ack_q[3:0], i_sleep_request, i_init_request};
		end
	end
	// One completion per unbroken stretch of i_tx_valid; the index toggles when no completion is signalled.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q <= 0;
			o_tx_done <= 1'b0;
			o_tx_done_index <= '0;
		end else begin
			o_tx_done <= 1'b0;
			o_tx_done_index <= ~o_tx_done_index;
			if (!i_tx_valid) begin
				cnt_q <= 0;
			end else if (cnt_q == DONE_DLY) begin
				o_tx_done <= 1'b1;
				o_tx_done_index <= i_tx_index;
				cnt_q <= cnt_q + 1;
			end else if (cnt_q < DONE_DLY) begin
				cnt_q <= cnt_q + 1;
			end
		end
	end
	task automatic send_frame(input logic [31:0] id, input logic [3:0] dlc, input logic [63:0] pl);
		@(posedge i_core_clk);
		o_rx_valid <= 1'b1;
		o_rx_ident <= id;
		o_rx_dlc <= dlc;
		o_rx_payload <= pl;
		@(posedge i_core_clk);
		o_rx_valid <= 1'b0;
		o_rx_ident <= ~id;
		o_rx_dlc <= ~dlc;
		o_rx_payload <= ~pl;
	endtask : send_frame
endmodule : cafm_engine_model

// >>> bench/tb_top.sv
// Self-checking bench for the acceptance filter, message buffers and register file.
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ERRC = 8'h2a;
	logic i_core_clk, i_resetn, psel, penable, pwrite, pready, pslverr, err;
	logic slp_rq, ini_rq, slp_ak, ini_ak, rx_valid, tx_valid, tx_ide, tx_rtr, tx_done, irq;
	logic [7:0] paddr, txerr;
	logic [31:0] pwdata, prdata, rdat, rx_ident, tx_ident;
	logic [3:0] pstrb, rx_dlc, tx_dlc;
	logic [63:0] rx_pl, tx_pl;
	logic [2:0] tx_pend;
	logic [1:0] tx_idx, done_idx;
	logic [7:0] cv [8] = '{8'h12, 8'h20, 8'h34, 8'h56, 8'h00, 8'h1f, 8'h00, 8'h0f};
	int error_cnt = 0;
	int check_count = 0;
	cafm_top #(.NUM_TXBUF(3)) dut (.i_core_clk, .i_resetn, .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
		.o_pslverr(pslverr), .o_prdata(prdata), .o_sleep_request(slp_rq), .o_init_request(ini_rq),
		.i_sleep_acknowledge(slp_ak), .i_init_acknowledge(ini_ak), .i_tx_error_count(txerr),
		.i_rx_valid(rx_valid), .i_rx_ident(rx_ident), .i_rx_dlc(rx_dlc), .i_rx_payload(rx_pl),
		.o_tx_pending(tx_pend), .o_tx_valid(tx_valid), .o_tx_index(tx_idx), .o_tx_ident(tx_ident),
		.o_tx_ide(tx_ide), .o_tx_rtr(tx_rtr), .o_tx_dlc(tx_dlc), .o_tx_payload(tx_pl),
		.i_tx_done(tx_done), .i_tx_done_index(done_idx), .o_irq(irq));
	cafm_engine_model #(.TW(2), .ERR_COUNT(ERRC)) peer (.i_core_clk, .i_resetn,
		.i_sleep_request(slp_rq), .i_init_request(ini_rq), .o_sleep_acknowledge(slp_ak),
		.o_init_acknowledge(ini_ak), .o_tx_error_count(txerr), .o_rx_valid(rx_valid),
		.o_rx_ident(rx_ident), .o_rx_dlc(rx_dlc), .o_rx_payload(rx_pl), .i_tx_valid(tx_valid),
		.i_tx_index(tx_idx), .o_tx_done(tx_done), .o_tx_done_index(done_idx));
	initial begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_core_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_core_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK($sformatf("rd_%h", a), e, rdat)
	endtask : rchk
	task automatic wait_for(ref logic s, input logic v, input string nm);
		int n;
		n = 0;
		while (s !== v && n < 100) begin
			@(posedge i_core_clk);
			n++;
		end
		`CHK(nm, v, s)
	endtask : wait_for
	task results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial begin
		repeat (20000) @(posedge i_core_clk);
		error_cnt++;
		results();
	end
	initial begin
		i_resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h1;
		repeat (10) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		rchk(cafm_pkg::OFF_CODE0, 32'h0);
		rchk(cafm_pkg::OFF_TXEMPTY, 32'h7);
		apb(1'b1, cafm_pkg::OFF_CODE0, 32'h12);
		rchk(cafm_pkg::OFF_CODE0, 32'h0);
		apb(1'b1, cafm_pkg::OFF_TXERR, 32'hff);
		rchk(cafm_pkg::OFF_TXERR, 32'h0);
		apb(1'b1, cafm_pkg::OFF_CTRL, 32'h2);
		rchk(cafm_pkg::OFF_TXERR, 32'h0);
		wait_for(ini_ak, 1'b1, "init_ack");
		rchk(cafm_pkg::OFF_TXERR, {24'h0, ERRC});
		for (int i = 0; i < 8; i++) apb(1'b1, 8'(cafm_pkg::OFF_CODE0 + 4 * i), {24'h0, cv[i]});
		rchk(8'h34, 32'h1f);
		apb(1'b1, cafm_pkg::OFF_CTRL, 32'h0);
		wait_for(ini_ak, 1'b0, "init_ack");
		apb(1'b1, cafm_pkg::OFF_CTRL, 32'h1);
		wait_for(slp_ak, 1'b1, "sleep_ack");
		rchk(cafm_pkg::OFF_TXERR, {24'h0, ERRC});
		rchk(cafm_pkg::OFF_MODE_STAT, 32'h1);
		rchk(cafm_pkg::OFF_CTRL, 32'h1);
		apb(1'b1, cafm_pkg::OFF_CODE0, 32'hee);
		rchk(cafm_pkg::OFF_CODE0, 32'h12);
		apb(1'b1, cafm_pkg::OFF_CTRL, 32'h0);
		wait_for(slp_ak, 1'b0, "sleep_ack");
		apb(1'b1, cafm_pkg::OFF_IRQ_MASK, 32'h7);
		rchk(cafm_pkg::OFF_IRQ_MASK, 32'h7);
		peer.send_frame(32'h1230_ffff, 4'h2, 64'ha1a2_a3a4_a5a6_a7a8);
		rchk(cafm_pkg::OFF_RXFLAG, 32'h1);
		`CHK("irq", 1'b1, irq)
		rchk(8'h44, 32'h30);
		rchk(8'h54, 32'ha2);
		rchk(8'h58, 32'h0);
		rchk(cafm_pkg::OFF_IRQ_STAT, 32'h1);
		peer.send_frame(32'h1220_0000, 4'h0, 64'h0);
		rchk(cafm_pkg::OFF_IRQ_STAT, 32'h4);
		rchk(8'h44, 32'h30);
		`CHK("irq", 1'b0, irq)
		apb(1'b1, cafm_pkg::OFF_RXFLAG, 32'h1);
		rchk(8'h40, 32'h0);
		peer.send_frame(32'h1320_0000, 4'h0, 64'h0);
		rchk(cafm_pkg::OFF_RXFLAG, 32'h0);
		peer.send_frame(32'h1228_0056, 4'h0, 64'h0);
		rchk(cafm_pkg::OFF_RXFLAG, 32'h0);
		peer.send_frame(32'h1228_345a, 4'h0, 64'h0);
		rchk(cafm_pkg::OFF_RXFLAG, 32'h1);
		rchk(8'h4c, 32'h5a);
		apb(1'b1, cafm_pkg::OFF_IRQ_MASK, 32'h0);
		rchk(8'hc0, 32'h0);
		`CHK("slverr", 1'b1, err)
		rchk(8'h02, 32'h0);
		`CHK("slverr", 1'b1, err)
		`CHK("irq", 1'b0, irq)
		apb(1'b1, cafm_pkg::OFF_TBSEL, 32'h1);
		apb(1'b1, cafm_pkg::OFF_TBSEL, 32'h3);
		rchk(cafm_pkg::OFF_TBSEL, 32'h1);
		pstrb <= 4'h0;
		apb(1'b1, cafm_pkg::OFF_TBSEL, 32'h2);
		pstrb <= 4'h1;
		rchk(cafm_pkg::OFF_TBSEL, 32'h1);
		apb(1'b1, 8'h80, 32'h55);
		apb(1'b1, 8'h84, 32'h30);
		apb(1'b1, 8'h90, 32'hc3);
		apb(1'b1, 8'hb0, 32'h1);
		apb(1'b1, cafm_pkg::OFF_TXEMPTY, 32'h2);
		wait_for(tx_valid, 1'b1, "tx_valid");
		`CHK("tx_head", {2'h1, 1'b1, 1'b0}, {tx_idx, tx_rtr, tx_ide})
		`CHK("tx_body", {4'h1, 8'hc3}, {tx_dlc, tx_pl[63:56]})
		`CHK("tx_ident", 16'h5530, tx_ident[31:16])
		apb(1'b1, 8'h80, 32'haa);
		rchk(8'h80, 32'h55);
		wait_for(tx_valid, 1'b0, "tx_valid");
		rchk(cafm_pkg::OFF_TXEMPTY, 32'h7);
		rchk(cafm_pkg::OFF_IRQ_STAT, 32'h3);
		results();
	end
endmodule : tb_top
